// ---- design/spab_bank.sv ----
// Special purpose register bank with hypervisor and privilege access checks.
import spab_pkg::*;

module spab_bank (
    input wire logic CLK, // Core clock.
    input wire logic RST, // Power-on reset, asynchronous, active high.
    input wire spab_pkg::spab_req_s REQ, // Move-to or move-from request.
    input wire logic [63:0] VERSION_VAL, // Version value caught after reset.
    output spab_pkg::spab_rsp_s RSP, // Registered answer.
    output logic [1:0] THREAD_EN, // Thread-enable field of the control register.
    output logic READY // High once the load phase has finished.
);
    import spab_pkg::*;

    // ------------------------------------------------------------
    // Decode.
    // ------------------------------------------------------------
    logic [9:0] spr_num;
    logic [3:0] ts_idx;
    logic [1:0] sh_idx;
    logic ts_hit;
    logic sh_hit;
    logic is_ver;
    logic is_pid;
    logic is_ctrl_wr;
    logic is_ctrl_rd;
    logic is_class32;
    logic illegal;
    logic do_write;
    logic [63:0] rd_val;
    logic [63:0] ts_r [SPAB_THREADS][TS_NUM];
    logic [63:0] sh_r [SH_NUM];
    logic [63:0] version_r;
    logic [1:0] te_r;
    logic [1:0] te_nxt;
    spab_state_e state_r;
    spab_rsp_s rsp_r;

    assign spr_num = {REQ.spr_field[SPAB_HALF_W-1:0], REQ.spr_field[2*SPAB_HALF_W-1:SPAB_HALF_W]};

    always_comb begin
        ts_hit = 1'b1;
        ts_idx = 4'h0;
        case (spr_num)
            DATA_CLASS_ID_0_NUM: ts_idx = 4'(TS_DCID0);
            DATA_RANGE_START_1_NUM: ts_idx = 4'(TS_DRS1);
            DATA_RANGE_MASK_1_NUM: ts_idx = 4'(TS_DRM1);
            DATA_CLASS_ID_1_NUM: ts_idx = 4'(TS_DCID1);
            INSTR_RANGE_START_0_NUM: ts_idx = 4'(TS_IRS0);
            INSTR_RANGE_MASK_0_NUM: ts_idx = 4'(TS_IRM0);
            INSTR_CLASS_ID_0_NUM: ts_idx = 4'(TS_ICID0);
            INSTR_RANGE_START_1_NUM: ts_idx = 4'(TS_IRS1);
            INSTR_RANGE_MASK_1_NUM: ts_idx = 4'(TS_IRM1);
            INSTR_CLASS_ID_1_NUM: ts_idx = 4'(TS_ICID1);
            DATA_BREAKPOINT_ADDR_NUM: ts_idx = 4'(TS_DBA);
            DATA_BREAKPOINT_EXT_NUM: ts_idx = 4'(TS_DBX);
            default: ts_hit = 1'b0;
        endcase
    end

    always_comb begin
        sh_hit = 1'b1;
        sh_idx = 2'h0;
        case (spr_num)
            HW_IMPL_CONFIG_0_NUM: sh_idx = 2'(SH_HW0);
            HW_IMPL_CONFIG_1_NUM: sh_idx = 2'(SH_HW1);
            HW_IMPL_CONFIG_4_NUM: sh_idx = 2'(SH_HW4);
            HW_IMPL_CONFIG_6_NUM: sh_idx = 2'(SH_HW6);
            default: sh_hit = 1'b0;
        endcase
    end

    assign is_ver = (spr_num == PROCESSOR_VERSION_NUM);
    assign is_pid = (spr_num == PROCESSOR_IDENT_NUM);
    // The control register write number sits outside this bank's table.
    assign is_ctrl_wr = (spr_num == CTRL_WRITE_NUM);
    assign is_ctrl_rd = (spr_num == CTRL_READ_NUM);
    assign is_class32 = ts_hit && (ts_idx == 4'(TS_DCID0) || ts_idx == 4'(TS_DCID1)
        || ts_idx == 4'(TS_ICID0) || ts_idx == 4'(TS_ICID1));

    // ------------------------------------------------------------
    // Privilege checks.
    // ------------------------------------------------------------
    always_comb begin
        illegal = 1'b0;
        if (REQ.valid && state_r == SPAB_ST_RUN) begin
            if ((ts_hit || sh_hit || is_ver || is_pid) && REQ.pr) begin
                illegal = 1'b1;
            end else if ((ts_hit || sh_hit) && REQ.is_write && !REQ.hv) begin
                illegal = 1'b1;
            // shared copies readable only in hypervisor state
            end else if (sh_hit && !REQ.hv) begin
                illegal = 1'b1;
            // Control write is privileged; the thread-enable part is checked apart.
            end else if (is_ctrl_wr && REQ.is_write && REQ.pr) begin
                illegal = 1'b1;
            end
        end
    end

    // only implemented writable numbers are written
    assign do_write = REQ.valid && REQ.is_write && !illegal && state_r == SPAB_ST_RUN;

    // ------------------------------------------------------------
    // Load phase.
    // ------------------------------------------------------------
    // bank idles until reset load completes
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_r <= SPAB_ST_IDLE;
        end else begin
            case (state_r)
                SPAB_ST_IDLE: state_r <= SPAB_ST_RUN;
                SPAB_ST_RUN: state_r <= SPAB_ST_RUN;
                default: state_r <= SPAB_ST_IDLE;
            endcase
        end
    end

    // The version strap is caught on the first clock after release, never under reset.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            version_r <= SPAB_RESET_VAL;
        end else if (state_r == SPAB_ST_IDLE) begin
            version_r <= VERSION_VAL;
        end
    end

    // ------------------------------------------------------------
    // Storage.
    // ------------------------------------------------------------
    // per-thread copies
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            for (int t = 0; t < SPAB_THREADS; t++) begin
                for (int i = 0; i < TS_NUM; i++) begin
                    ts_r[t][i] <= SPAB_RESET_VAL;
                end
            end
        end else if (do_write && ts_hit) begin
            // class registers keep only the low word
            // all implemented bits stored as written
            if (is_class32) begin
                ts_r[REQ.thread][ts_idx] <= {32'h0000_0000, REQ.wdata[SPAB_CLASS_W-1:0]};
            end else begin
                ts_r[REQ.thread][ts_idx] <= REQ.wdata;
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < SH_NUM; i++) begin
                sh_r[i] <= SPAB_RESET_VAL;
            end
        end else if (do_write && sh_hit) begin
            sh_r[sh_idx] <= REQ.wdata;
        end
    end

    always_comb begin
        te_nxt = te_r;
        if (do_write && is_ctrl_wr && REQ.hv) begin
            te_nxt = REQ.wdata[SPAB_TE_LSB+1:SPAB_TE_LSB];
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            te_r <= SPAB_TE_RESET;
        end else begin
            te_r <= te_nxt;
        end
    end

    // ------------------------------------------------------------
    // Read mux.
    // ------------------------------------------------------------
    always_comb begin
        rd_val = SPAB_RESET_VAL;
        if (ts_hit) begin
            rd_val = ts_r[REQ.thread][ts_idx];
        end else if (sh_hit) begin
            rd_val = sh_r[sh_idx];
        end else if (is_ver) begin
            rd_val = version_r;
        end else if (is_pid) begin
            rd_val = {63'h0, REQ.thread};
        end else if (is_ctrl_rd) begin
            rd_val = {32'h0000_0000, 8'h00, te_r, 22'h000000};
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rsp_r <= '0;
        end else begin
            rsp_r.done <= REQ.valid && state_r == SPAB_ST_RUN;
            rsp_r.prog_int <= illegal;
            rsp_r.rdata <= (REQ.valid && !REQ.is_write && !illegal && state_r == SPAB_ST_RUN)
                ? rd_val : SPAB_RESET_VAL;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            READY <= 1'b0;
        end else begin
            READY <= (state_r == SPAB_ST_RUN) || (state_r == SPAB_ST_IDLE);
        end
    end

    assign RSP = rsp_r;
    assign THREAD_EN = te_r;

endmodule // spab_bank

// ---- design/spab_pkg.sv ----
// Package for the special purpose register access and privilege bank.
package spab_pkg;

    // ------------------------------------------------------------
    // Register numbers, given as a 10-bit logical value.
    // ------------------------------------------------------------
    localparam logic [9:0] DATA_CLASS_ID_0_NUM = 10'h3BA;
    localparam logic [9:0] DATA_RANGE_START_1_NUM = 10'h3BB;
    localparam logic [9:0] DATA_RANGE_MASK_1_NUM = 10'h3BC;
    localparam logic [9:0] DATA_CLASS_ID_1_NUM = 10'h3BD;
    localparam logic [9:0] INSTR_RANGE_START_0_NUM = 10'h3D0;
    localparam logic [9:0] INSTR_RANGE_MASK_0_NUM = 10'h3D1;
    localparam logic [9:0] INSTR_CLASS_ID_0_NUM = 10'h3D2;
    localparam logic [9:0] INSTR_RANGE_START_1_NUM = 10'h3D3;
    localparam logic [9:0] INSTR_RANGE_MASK_1_NUM = 10'h3D4;
    localparam logic [9:0] INSTR_CLASS_ID_1_NUM = 10'h3D5;
    localparam logic [9:0] HW_IMPL_CONFIG_0_NUM = 10'h3F0;
    localparam logic [9:0] HW_IMPL_CONFIG_1_NUM = 10'h3F1;
    localparam logic [9:0] HW_IMPL_CONFIG_4_NUM = 10'h3F4;
    localparam logic [9:0] DATA_BREAKPOINT_ADDR_NUM = 10'h3F5;
    localparam logic [9:0] DATA_BREAKPOINT_EXT_NUM = 10'h3F7;
    localparam logic [9:0] HW_IMPL_CONFIG_6_NUM = 10'h3F9;
    localparam logic [9:0] PROCESSOR_VERSION_NUM = 10'h3FE;
    localparam logic [9:0] PROCESSOR_IDENT_NUM = 10'h3FF;
    // The control register answers on one number for reads and another for writes.
    localparam logic [9:0] CTRL_READ_NUM = 10'h088;
    localparam logic [9:0] CTRL_WRITE_NUM = 10'h098;

    // ------------------------------------------------------------
    // Widths, thread count and reset values.
    // ------------------------------------------------------------
    localparam int SPAB_THREADS = 2;
    localparam int SPAB_HALF_W = 5;
    localparam int SPAB_CLASS_W = 32;
    localparam logic [63:0] SPAB_RESET_VAL = 64'h0000_0000_0000_0000;
    // Arbitrary neutral version code; real parts strap their own value.
    localparam logic [63:0] SPAB_VERSION_DEFAULT = 64'h0000_0000_0001_0000;
    // Thread-enable field of the control register, bits 8:9 in big-endian order.
    localparam int SPAB_TE_LSB = 22;
    localparam logic [1:0] SPAB_TE_RESET = 2'h3;

    // Per-thread register slot indices.
    localparam int TS_DCID0 = 0;
    localparam int TS_DRS1 = 1;
    localparam int TS_DRM1 = 2;
    localparam int TS_DCID1 = 3;
    localparam int TS_IRS0 = 4;
    localparam int TS_IRM0 = 5;
    localparam int TS_ICID0 = 6;
    localparam int TS_IRS1 = 7;
    localparam int TS_IRM1 = 8;
    localparam int TS_ICID1 = 9;
    localparam int TS_DBA = 10;
    localparam int TS_DBX = 11;
    localparam int TS_NUM = 12;

    // Shared register slot indices.
    localparam int SH_HW0 = 0;
    localparam int SH_HW1 = 1;
    localparam int SH_HW4 = 2;
    localparam int SH_HW6 = 3;
    localparam int SH_NUM = 4;

    typedef enum logic [1:0] {
        SPAB_CLS_NONE,
        SPAB_CLS_HV,
        SPAB_CLS_PRIV_RO,
        SPAB_CLS_CTRL_WR
    } spab_class_e;

    typedef enum {
        SPAB_ST_IDLE,
        SPAB_ST_RUN
    } spab_state_e;

    // One move-to or move-from request from the pipeline.
    typedef struct packed {
        logic valid;
        logic is_write;
        logic thread;
        logic [9:0] spr_field;
        logic [63:0] wdata;
        logic hv;
        logic pr;
    } spab_req_s;

    // Result answered to the pipeline one cycle later.
    typedef struct packed {
        logic done;
        logic prog_int;
        logic [63:0] rdata;
    } spab_rsp_s;

endpackage : spab_pkg

// ---- dv/spab_bank_bench.sv ----
// Self-checking bench for the register bank and its privilege checks.
module spab_bank_bench;
    import spab_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    // Arbitrary neutral version value for this run.
    localparam logic [63:0] VER = 64'h0000_0000_00A5_5A00;
    localparam logic [63:0] PV = 64'h1122_3344_5566_7788;
    localparam logic [63:0] Z = 64'h0;
    localparam logic O = 1'h0;
    localparam logic I = 1'h1;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    spab_req_s req;
    spab_rsp_s rsp;
    logic [1:0] te;
    logic rdy;
    int err_count = 0;
    int total_checks = 0;
    always #5 CLK = ~CLK;
    spab_bank spab_bank_inst (.CLK(CLK), .RST(RST), .REQ(req), .VERSION_VAL(VER),
        .RSP(rsp), .THREAD_EN(te), .READY(rdy));
    spab_pipe spab_pipe_inst (.CLK(CLK), .REQ(req), .RSP(rsp));
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic cmp(input logic [63:0] got, exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic acc(input logic wr, th, input logic [9:0] num, input logic [63:0] wd,
        input logic hv, pr, input logic [63:0] erd, input logic epi);
        logic [63:0] rd;
        logic pi, ok;
        spab_pipe_inst.op(wr, th, num, wd, hv, pr, rd, pi, ok);
        if (ok !== 1'b1) begin
            err_count++;
            $display("ERROR %0t: no answer from the bank", $time);
            end_of_test();
        end
        cmp(rd, erd, "read data");
        cmp({63'h0, pi}, {63'h0, epi}, "interrupt");
    endtask
    task automatic t_reset();
        RST <= 1'b1;
        repeat (16) @(posedge CLK);
        RST <= 1'b0;
        for (int i = 0; i < 8 && rdy !== 1'b1; i++) begin
            @(posedge CLK);
            #1;
        end
        cmp({63'h0, rdy}, 64'h1, "ready");
        cmp({62'h0, te}, 64'h3, "enable reset");
        acc(O, O, HW_IMPL_CONFIG_6_NUM, Z, I, O, Z, O);
        acc(O, I, DATA_RANGE_START_1_NUM, Z, I, O, Z, O);
        $display("Test reset done");
    endtask
    task automatic t_hv_regs();
        logic [9:0] n [12];
        logic [9:0] s [4];
        logic [63:0] p;
        n = '{DATA_CLASS_ID_0_NUM, DATA_RANGE_START_1_NUM, DATA_RANGE_MASK_1_NUM,
            DATA_CLASS_ID_1_NUM, INSTR_RANGE_START_0_NUM, INSTR_RANGE_MASK_0_NUM,
            INSTR_CLASS_ID_0_NUM, INSTR_RANGE_START_1_NUM, INSTR_RANGE_MASK_1_NUM,
            INSTR_CLASS_ID_1_NUM, DATA_BREAKPOINT_ADDR_NUM, DATA_BREAKPOINT_EXT_NUM};
        s = '{HW_IMPL_CONFIG_0_NUM, HW_IMPL_CONFIG_1_NUM, HW_IMPL_CONFIG_4_NUM,
            HW_IMPL_CONFIG_6_NUM};
        foreach (n[k]) begin
            p = 64'hF0E1_D2C3_B4A5_9600 + 64'(k);
            acc(I, O, n[k], p, I, O, Z, O);
            // Class-ID slots sit at every third place and keep only 32 bits.
            if (k % 3 == 0) p[63:32] = 32'h0;
            acc(O, O, n[k], Z, I, O, p, O);
            acc(O, I, n[k], Z, I, O, Z, O);
        end
        foreach (s[k]) begin
            p = 64'h0123_4567_89AB_CDE0 + 64'(k);
            acc(I, I, s[k], p, I, O, Z, O);
            acc(O, O, s[k], Z, I, O, p, O);
        end
        $display("Test hv_regs done");
    endtask
    task automatic t_refuse();
        acc(I, O, HW_IMPL_CONFIG_6_NUM, PV, I, O, Z, O);
        acc(I, O, HW_IMPL_CONFIG_6_NUM, ~PV, O, O, Z, I);
        acc(I, O, HW_IMPL_CONFIG_6_NUM, ~PV, I, I, Z, I);
        acc(O, O, HW_IMPL_CONFIG_6_NUM, Z, O, O, Z, I);
        acc(O, O, HW_IMPL_CONFIG_6_NUM, Z, I, O, PV, O);
        acc(I, I, DATA_BREAKPOINT_ADDR_NUM, ~PV, O, O, Z, I);
        acc(O, I, DATA_BREAKPOINT_ADDR_NUM, Z, I, I, Z, I);
        acc(O, I, DATA_BREAKPOINT_ADDR_NUM, Z, I, O, Z, O);
        acc(O, O, PROCESSOR_VERSION_NUM, Z, O, I, Z, I);
        acc(O, I, PROCESSOR_IDENT_NUM, Z, O, I, Z, I);
        $display("Test refuse done");
    endtask
    task automatic t_ro_unimpl();
        acc(I, O, 10'h3BE, ~PV, I, O, Z, O);
        acc(O, O, 10'h3BE, Z, I, O, Z, O);
        acc(I, O, PROCESSOR_VERSION_NUM, ~VER, I, O, Z, O);
        acc(O, O, PROCESSOR_VERSION_NUM, Z, O, O, VER, O);
        acc(O, O, PROCESSOR_IDENT_NUM, Z, O, O, Z, O);
        acc(O, I, PROCESSOR_IDENT_NUM, Z, O, O, 64'h1, O);
        acc(O, O, 10'h098, Z, I, O, Z, O);
        acc(O, O, HW_IMPL_CONFIG_6_NUM, Z, I, O, PV, O);
        $display("Test ro_unimpl done");
    endtask
    task automatic t_thread_en();
        acc(I, O, 10'h098, 64'h0040_0000, O, O, Z, O);
        cmp({62'h0, te}, 64'h3, "enable kept");
        acc(I, O, 10'h098, 64'h0040_0000, I, I, Z, I);
        cmp({62'h0, te}, 64'h3, "enable kept");
        acc(I, O, 10'h098, 64'h0040_0000, I, O, Z, O);
        cmp({62'h0, te}, 64'h1, "thread 0 suspended");
        acc(I, I, 10'h098, 64'h00C0_0000, I, O, Z, O);
        cmp({62'h0, te}, 64'h3, "thread 0 resumed");
        $display("Test thread_en done");
    endtask
    initial begin
        t_reset();
        t_hv_regs();
        t_refuse();
        t_ro_unimpl();
        t_thread_en();
        t_reset();
        end_of_test();
    end
endmodule // spab_bank_bench

// ---- dv/spab_bank_chk.sv ----
// Concurrent checks on the ports of the register bank.
module spab_bank_chk
    import spab_pkg::*;
(
    input wire logic CLK, // Core clock.
    input wire logic RST, // Reset.
    input wire spab_pkg::spab_req_s REQ, // Request.
    input wire spab_pkg::spab_rsp_s RSP, // Answer.
    input wire logic [1:0] THREAD_EN, // Thread enables.
    input wire logic READY // Ready.
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [9:0] num;
    logic take, bank, hw, legal;
    assign num = {REQ.spr_field[4:0], REQ.spr_field[9:5]};
    assign take = REQ.valid && READY;
    assign bank = num inside {[10'h3BA:10'h3BD], [10'h3D0:10'h3D5], 10'h3F5, 10'h3F7};
    assign hw = num inside {10'h3F0, 10'h3F1, 10'h3F4, 10'h3F9};
    assign legal = REQ.is_write && REQ.hv && !REQ.pr && num == 10'h098;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    a_done_after_take: assert property (take |=> RSP.done)
        else $error("done missing after a taken request");
    a_no_spurious_done: assert property (!take |=> !RSP.done)
        else $error("done without a request");
    a_int_with_done: assert property (RSP.prog_int |-> RSP.done && RSP.rdata == 64'h0)
        else $error("interrupt without done or with data");
    a_priv_refused: assert property (take && REQ.pr && (bank || hw || num >= 10'h3FE)
        |=> RSP.prog_int)
        else $error("problem state access not refused");
    a_hv_write_refused: assert property (take && REQ.is_write && !REQ.hv && (bank || hw)
        |=> RSP.prog_int)
        else $error("non-hypervisor write not refused");
    a_hv_access_ok: assert property (take && REQ.hv && !REQ.pr && (bank || hw)
        |=> !RSP.prog_int)
        else $error("legal hypervisor access refused");
    a_unimpl_reads_zero: assert property (take && !REQ.is_write && !REQ.pr
        && !(bank || hw || num >= 10'h3FE || num == 10'h088)
        |=> RSP.rdata == 64'h0 && !RSP.prog_int)
        else $error("unimplemented read not zero");
    a_write_data_zero: assert property (take && REQ.is_write |=> RSP.rdata == 64'h0)
        else $error("write answered with data");
    a_enable_kept: assert property (!(take && legal) |=> $stable(THREAD_EN))
        else $error("thread enable changed without a legal write");
    a_ident_thread: assert property (take && !REQ.is_write && !REQ.pr && num == 10'h3FF
        |=> RSP.rdata == {63'h0, $past(REQ.thread)})
        else $error("identity value does not match thread");
    c_refused: cover property (RSP.prog_int);
    c_enable_change: cover property (take && legal);
    c_ident_read: cover property (take && num == 10'h3FF);
endmodule // spab_bank_chk

bind spab_bank spab_bank_chk spab_bank_chk_inst (.CLK(CLK), .RST(RST), .REQ(REQ),
    .RSP(RSP), .THREAD_EN(THREAD_EN), .READY(READY));

// ---- dv/spab_pipe.sv ----
// Pipeline model that issues move-to and move-from requests to the bank.
module spab_pipe
    import spab_pkg::*;
(
    input wire logic CLK, // Core clock.
    output spab_pkg::spab_req_s REQ, // Request to the bank.
    input wire spab_pkg::spab_rsp_s RSP // Answer from the bank.
);
    timeunit 1ns;
    timeprecision 100ps;
    initial REQ = '0;
    // software ordering
    // Syncs around range, class and shared writes are taken as issued by software;
    // they leave no trace at these ports, and shared values written are harmless.
    task automatic op(input logic wr, th, input logic [9:0] num, input logic [63:0] wd,
        input logic hv, pr, output logic [63:0] rd, output logic pi, ok);
        ok = 1'b0;
        rd = 64'h0;
        pi = 1'b0;
        @(posedge CLK);
        REQ.valid <= 1'b1;
        REQ.is_write <= wr;
        REQ.thread <= th;
        REQ.spr_field <= {num[4:0], num[9:5]};
        REQ.wdata <= wd;
        REQ.hv <= hv;
        REQ.pr <= pr;
        @(posedge CLK);
        REQ.valid <= 1'b0;
        // Released data flips so a stale value is never mistaken for a live one.
        REQ.wdata <= ~wd;
        for (int i = 0; i < 4 && !ok; i++) begin
            #1;
            if (RSP.done === 1'b1) begin
                ok = 1'b1;
                rd = RSP.rdata;
                pi = RSP.prog_int;
            end else begin
                @(posedge CLK);
            end
        end
    endtask
endmodule // spab_pipe
